// ===== rtl/afe_cfg_defines.svh
// Register offsets, field positions, reset values and timing figures of the slot A settings.
`ifndef AFE_CFG_DEFINES_SVH
`define AFE_CFG_DEFINES_SVH

`define ADDR_POLARITY_ORDER 8'h17
`define ADDR_WINDOW 8'h39
`define ADDR_FRONT_END_CTRL 8'h42
`define ADDR_CHANNEL_GAIN 8'h55

`define ORDER_MSB 3
`define WIN_LEN_MSB 15
`define WIN_LEN_LSB 11
`define WIN_START_MSB 10
`define INT_GAIN_MSB 9
`define INT_GAIN_LSB 8
`define INT_BUF_BIT 7
`define IND_EN_BIT 6
`define TIA_GAIN_MSB 1
`define CH2_GAIN_LSB 0
`define CH3_GAIN_LSB 2
`define CH4_GAIN_LSB 4
`define CH_GAIN_MSB 5

`define RESET_ORDER 4'h0
`define RESET_WINDOW 16'h22fc
`define RESET_FRONT_END_CTRL 16'h1c38
`define RESET_CHANNEL_GAIN 6'h00

`define WIN_LEN_UNIT_NS 1000
`define WIN_START_UNIT_PS 31250
`define CLOCK_PERIOD_PS 25000
`define WIN_LEN_UNIT_CYCLES ((`WIN_LEN_UNIT_NS * 1000) / `CLOCK_PERIOD_PS)

`endif

// ===== rtl/afe_cfg_pkg.sv
// Types shared by the slot A front end configuration logic.
package afe_cfg_pkg;
  typedef enum logic [1:0] {TIA_200K, TIA_100K, TIA_50K, TIA_25K} tia_gain_t;
  typedef enum logic [1:0] {RINT_400K, RINT_200K, RINT_100K, RINT_UNUSED} int_res_t;
  typedef enum logic {SEQ_NORMAL, SEQ_REVERSED} pulse_seq_t;
endpackage : afe_cfg_pkg

// ===== rtl/slot_a_afe_config_regs.sv
// Slot A front end configuration registers and the settings they drive.
`timescale 1ns/1ps
`include "afe_cfg_defines.svh"

module slot_a_afe_config_regs
  import afe_cfg_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  input wire logic SLOT_START_IN,
  input wire logic PULSE_IN,
  output pulse_seq_t PULSE_SEQ_OUT,
  output logic [1:0] PULSE_INDEX_OUT,
  output logic [4:0] WINDOW_LENGTH_OUT,
  output logic [10:0] WINDOW_START_OUT,
  output logic [15:0] WINDOW_LENGTH_CYCLES_OUT,
  output logic INTEGRATOR_AS_BUFFER_OUT,
  output int_res_t INTEGRATOR_RES_OUT,
  output logic BUFFER_GAIN_REDUCED_OUT,
  output tia_gain_t CH1_GAIN_OUT,
  output tia_gain_t CH2_GAIN_OUT,
  output tia_gain_t CH3_GAIN_OUT,
  output tia_gain_t CH4_GAIN_OUT
);

  // Picks a channel gain: its own field when individual gains are on, else the common field.
  function automatic tia_gain_t pick_gain(input logic ind_en, input logic [1:0] own,
                                          input logic [1:0] common);
    pick_gain = tia_gain_t'(ind_en ? own : common);
  endfunction : pick_gain

  logic [3:0] slot_a_pulse_polarity_bits;
  logic [15:0] window_reg;
  logic [15:0] front_end_ctrl;
  logic [5:0] channel_gain;
  logic [1:0] pulse_index;

  // Write decode for each register.
  wire wr_order = REG_WR_IN && (REG_ADDR_IN == `ADDR_POLARITY_ORDER);
  wire wr_window = REG_WR_IN && (REG_ADDR_IN == `ADDR_WINDOW);
  wire wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `ADDR_FRONT_END_CTRL);
  wire wr_gain = REG_WR_IN && (REG_ADDR_IN == `ADDR_CHANNEL_GAIN);

  // Named fields of the stored registers.
  wire [4:0] slot_a_window_length = window_reg[`WIN_LEN_MSB:`WIN_LEN_LSB];
  wire [10:0] slot_a_window_start = window_reg[`WIN_START_MSB:0];
  wire [1:0] slot_a_integrator_gain_sel = front_end_ctrl[`INT_GAIN_MSB:`INT_GAIN_LSB];
  wire slot_a_integrator_buffer_sel = front_end_ctrl[`INT_BUF_BIT];
  wire slot_a_individual_gain_enable = front_end_ctrl[`IND_EN_BIT];
  wire [1:0] slot_a_common_gain = front_end_ctrl[`TIA_GAIN_MSB:0];
  wire [1:0] slot_a_ch2_transimpedance_gain = channel_gain[`CH2_GAIN_LSB+1:`CH2_GAIN_LSB];
  wire [1:0] slot_a_ch3_transimpedance_gain = channel_gain[`CH3_GAIN_LSB+1:`CH3_GAIN_LSB];
  wire [1:0] slot_a_ch4_gain = channel_gain[`CH4_GAIN_LSB+1:`CH4_GAIN_LSB];

  // Read multiplexer; unmapped addresses and the bits above the order and gain fields read as zero.
  wire [15:0] next_rdata =
    (REG_ADDR_IN == `ADDR_POLARITY_ORDER) ? {12'h000, slot_a_pulse_polarity_bits} :
    (REG_ADDR_IN == `ADDR_WINDOW) ? window_reg :
    (REG_ADDR_IN == `ADDR_FRONT_END_CTRL) ? front_end_ctrl :
    (REG_ADDR_IN == `ADDR_CHANNEL_GAIN) ? {10'h000, channel_gain} : 16'h0000;

  // Polarity of the current pulse taken from its order bit.
  wire next_seq_bit = slot_a_pulse_polarity_bits[pulse_index];
  // Integrator resistor in normal mode, buffer gain flag in buffer mode.
  wire next_as_buffer = slot_a_integrator_buffer_sel;
  wire next_reduced = next_as_buffer && (slot_a_integrator_gain_sel == 2'h2);
  wire [1:0] next_res = next_as_buffer ? 2'h3 : slot_a_integrator_gain_sel;
  wire [15:0] next_len_cycles = 16'(slot_a_window_length * `WIN_LEN_UNIT_CYCLES);

  // Register storage, written by the host and restored on reset.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      slot_a_pulse_polarity_bits <= `RESET_ORDER;
      window_reg <= `RESET_WINDOW;
      front_end_ctrl <= `RESET_FRONT_END_CTRL;
      channel_gain <= `RESET_CHANNEL_GAIN;
    end else begin
      if (wr_order) slot_a_pulse_polarity_bits <= REG_WDATA_IN[`ORDER_MSB:0];
      if (wr_window) window_reg <= REG_WDATA_IN;
      if (wr_ctrl) front_end_ctrl <= REG_WDATA_IN;
      if (wr_gain) channel_gain <= REG_WDATA_IN[`CH_GAIN_MSB:0];
    end
  end

  // Pulse counter that wraps after the fourth pulse and restarts with each slot.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || SLOT_START_IN) begin
      pulse_index <= 2'h0;
    end else if (PULSE_IN) begin
      pulse_index <= pulse_index + 2'h1;
    end
  end

  // Registered outputs toward the analog settings and the host read port.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 16'h0000;
      PULSE_SEQ_OUT <= SEQ_NORMAL;
      PULSE_INDEX_OUT <= 2'h0;
      WINDOW_LENGTH_OUT <= 5'h00;
      WINDOW_START_OUT <= 11'h000;
      WINDOW_LENGTH_CYCLES_OUT <= 16'h0000;
      INTEGRATOR_AS_BUFFER_OUT <= 1'b0;
      INTEGRATOR_RES_OUT <= RINT_400K;
      BUFFER_GAIN_REDUCED_OUT <= 1'b0;
      CH1_GAIN_OUT <= TIA_200K;
      CH2_GAIN_OUT <= TIA_200K;
      CH3_GAIN_OUT <= TIA_200K;
      CH4_GAIN_OUT <= TIA_200K;
    end else begin
      REG_RDATA_OUT <= next_rdata;
      PULSE_SEQ_OUT <= pulse_seq_t'(next_seq_bit);
      PULSE_INDEX_OUT <= pulse_index;
      WINDOW_LENGTH_OUT <= slot_a_window_length;
      WINDOW_START_OUT <= slot_a_window_start;
      WINDOW_LENGTH_CYCLES_OUT <= next_len_cycles;
      INTEGRATOR_AS_BUFFER_OUT <= next_as_buffer;
      INTEGRATOR_RES_OUT <= int_res_t'(next_res);
      BUFFER_GAIN_REDUCED_OUT <= next_reduced;
      CH1_GAIN_OUT <= tia_gain_t'(slot_a_common_gain);
      CH2_GAIN_OUT <= pick_gain(slot_a_individual_gain_enable,
                                slot_a_ch2_transimpedance_gain, slot_a_common_gain);
      CH3_GAIN_OUT <= pick_gain(slot_a_individual_gain_enable,
                                slot_a_ch3_transimpedance_gain, slot_a_common_gain);
      CH4_GAIN_OUT <= pick_gain(slot_a_individual_gain_enable, slot_a_ch4_gain,
                                slot_a_common_gain);
    end
  end

  // Checks on the settings and the pulse sequencing.
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  order_bit_select_a: assert property (
    !PULSE_IN && !SLOT_START_IN && !wr_order ##1 1'b1 |->
      PULSE_SEQ_OUT == pulse_seq_t'(slot_a_pulse_polarity_bits[PULSE_INDEX_OUT]))
    else $error("Pulse polarity does not follow its order bit.");

  seq_polarity_a: assert property (
    slot_a_pulse_polarity_bits[pulse_index] |=> PULSE_SEQ_OUT == SEQ_REVERSED)
    else $error("A set order bit did not give a reversed sequence.");

  seq_normal_a: assert property (
    !slot_a_pulse_polarity_bits[pulse_index] |=> PULSE_SEQ_OUT == SEQ_NORMAL)
    else $error("A clear order bit did not give a normal sequence.");

  slot_restart_a: assert property (
    SLOT_START_IN |=> pulse_index == 2'h0)
    else $error("Pulse counter did not restart with the slot.");

  pulse_wrap_a: assert property (
    (pulse_index == 2'h3) && PULSE_IN && !SLOT_START_IN |=> pulse_index == 2'h0)
    else $error("Pulse counter did not restart after the fourth pulse.");

  window_fields_a: assert property (
    wr_window |=> ##1 (WINDOW_LENGTH_OUT == $past(REG_WDATA_IN[15:11], 2)) &&
      (WINDOW_START_OUT == $past(REG_WDATA_IN[10:0], 2)))
    else $error("Window fields did not follow the write.");

  window_reset_a: assert property (
    $fell(RST_IN) |-> (window_reg == `RESET_WINDOW) && (front_end_ctrl == `RESET_FRONT_END_CTRL))
    else $error("Window or control register lost its reset value.");

  integ_res_a: assert property (
    !next_as_buffer && (slot_a_integrator_gain_sel == 2'h1) |=>
      INTEGRATOR_RES_OUT == RINT_200K)
    else $error("Integrator resistor code wrong in normal mode.");

  buffer_gain_a: assert property (
    next_as_buffer && (slot_a_integrator_gain_sel != 2'h2) |=> !BUFFER_GAIN_REDUCED_OUT)
    else $error("Buffer gain reduced for a unity code.");

  buffer_mode_a: assert property (
    wr_ctrl && !REG_WDATA_IN[7] |=> ##1 !INTEGRATOR_AS_BUFFER_OUT)
    else $error("Integrator left normal configuration with buffer bit clear.");

  buffer_enter_a: assert property (
    wr_ctrl && REG_WDATA_IN[7] |=> ##1 INTEGRATOR_AS_BUFFER_OUT)
    else $error("Integrator did not become a buffer.");

  ch3_gain_a: assert property (
    slot_a_individual_gain_enable |=> CH3_GAIN_OUT == tia_gain_t'($past(channel_gain[3:2])))
    else $error("Channel 3 gain not from its own field.");

  ch2_gain_a: assert property (
    slot_a_individual_gain_enable |=> CH2_GAIN_OUT == tia_gain_t'($past(channel_gain[1:0])))
    else $error("Channel 2 gain not from its own field.");

  common_gain_a: assert property (
    !slot_a_individual_gain_enable |=> (CH4_GAIN_OUT == CH1_GAIN_OUT) &&
      (CH2_GAIN_OUT == CH1_GAIN_OUT) && (CH3_GAIN_OUT == CH1_GAIN_OUT))
    else $error("Common gain did not reach all channels.");

  ch4_gain_a: assert property (
    slot_a_individual_gain_enable |=> CH4_GAIN_OUT == tia_gain_t'($past(channel_gain[5:4])))
    else $error("Channel 4 gain not from its own field.");

  ch1_common_a: assert property (
    slot_a_individual_gain_enable |=> CH1_GAIN_OUT == tia_gain_t'($past(front_end_ctrl[1:0])))
    else $error("Channel 1 gain not from the common field.");

  // The order bits may only move on a write to their register or on reset.
  order_hold_a: assert property (
    !wr_order |=> $stable(slot_a_pulse_polarity_bits))
    else $error("Order bits changed without a write.");

  readback_a: assert property (
    wr_window ##1 (REG_ADDR_IN == `ADDR_WINDOW) && !REG_WR_IN |=>
      REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("Window register did not read back its write.");

endmodule : slot_a_afe_config_regs

// ===== tb/slot_a_afe_config_regs_test.sv
// Self-checking bench for the slot A front end configuration registers.
`timescale 1ns/1ps
`include "afe_cfg_defines.svh"

module slot_a_afe_config_regs_test;
  import afe_cfg_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic start = 1'b0;
  logic pulse = 1'b0;
  logic [15:0] rdata, wcyc;
  logic [1:0] idx;
  logic [4:0] wlen;
  logic [10:0] wstart;
  logic asbuf, red;
  pulse_seq_t seq;
  int_res_t res;
  tia_gain_t g1, g2, g3, g4;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  // The block under test, every port driven or watched by the bench.
  slot_a_afe_config_regs slot_a_afe_config_regs_inst (.CLOCK_IN(clock), .RST_IN(rst),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .SLOT_START_IN(start), .PULSE_IN(pulse), .PULSE_SEQ_OUT(seq), .PULSE_INDEX_OUT(idx),
    .WINDOW_LENGTH_OUT(wlen), .WINDOW_START_OUT(wstart), .WINDOW_LENGTH_CYCLES_OUT(wcyc),
    .INTEGRATOR_AS_BUFFER_OUT(asbuf), .INTEGRATOR_RES_OUT(res), .BUFFER_GAIN_REDUCED_OUT(red),
    .CH1_GAIN_OUT(g1), .CH2_GAIN_OUT(g2), .CH3_GAIN_OUT(g3), .CH4_GAIN_OUT(g4));

  // A 40 MHz clock, and a cycle ceiling that cuts a hang short.
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A write is taken at the second edge, and the settings have landed two edges later.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    repeat (2) @(posedge clock);
    #1;
    chk(what, exp, rdata);
  endtask : rd_reg

  task automatic reset_values();
    rd_reg(`ADDR_POLARITY_ORDER, 16'h0000, "order");
    rd_reg(`ADDR_WINDOW, 16'h22fc, "window");
    rd_reg(`ADDR_FRONT_END_CTRL, 16'h1c38, "ctrl");
    rd_reg(`ADDR_CHANNEL_GAIN, 16'h0000, "gain");
    rd_reg(8'h20, 16'h0000, "unmapped");
    chk("length", 16'h0004, {11'h0, wlen});
    chk("start", 16'h02fc, {5'h0, wstart});
    chk("buffer", 16'h0000, {15'h0, asbuf});
  endtask : reset_values

  // Both field extremes of the window register, read back as written.
  task automatic window_fields();
    logic [15:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'hf801 : 16'h07ff;
      wr_reg(`ADDR_WINDOW, v);
      chk("length", {11'h0, v[15:11]}, {11'h0, wlen});
      chk("cycles", 16'(v[15:11]) * 16'h0028, wcyc);
      chk("start", {5'h0, v[10:0]}, {5'h0, wstart});
      rd_reg(`ADDR_WINDOW, v, "window");
    end
  endtask : window_fields

  // Gain codes 0 to 2 in integrator mode and in buffer mode.
  task automatic ctrl_modes();
    logic [15:0] d;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 3; c++) begin
        d = {6'h07, 2'(c), 1'(b), 7'h38};
        wr_reg(`ADDR_FRONT_END_CTRL, d);
        chk("buffer", {15'h0, 1'(b)}, {15'h0, asbuf});
        chk("res", (b == 0) ? 16'(c) : 16'h0003, {14'h0, res});
        chk("reduced", {15'h0, 1'(b == 1 && c == 2)}, {15'h0, red});
      end
    end
  endtask : ctrl_modes

  // Individual gains on and off, with the unused upper bits dropped.
  task automatic gain_select();
    wr_reg(`ADDR_CHANNEL_GAIN, 16'hffe4);
    rd_reg(`ADDR_CHANNEL_GAIN, 16'h0024, "gain");
    wr_reg(`ADDR_FRONT_END_CTRL, 16'h1c7b);
    chk("ch1", 16'h0003, {14'h0, g1});
    chk("ch2", 16'h0000, {14'h0, g2});
    chk("ch3", 16'h0001, {14'h0, g3});
    chk("ch4", 16'h0002, {14'h0, g4});
    wr_reg(`ADDR_FRONT_END_CTRL, 16'h1c3b);
    chk("ch2", 16'h0003, {14'h0, g2});
    chk("ch3", 16'h0003, {14'h0, g3});
    chk("ch1", 16'h0003, {14'h0, g1});
    chk("ch4", 16'h0003, {14'h0, g4});
  endtask : gain_select

  // A restart, then eight pulses so that the pattern wraps past the fourth.
  task automatic pulse_order();
    logic [3:0] ord;
    ord = 4'hd;
    wr_reg(`ADDR_POLARITY_ORDER, 16'hfffd);
    rd_reg(`ADDR_POLARITY_ORDER, 16'h000d, "order");
    @(posedge clock);
    start <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      start <= 1'b0;
      pulse <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk("index", 16'(i % 4), {14'h0, idx});
      chk("seq", {15'h0, ord[i % 4]}, {15'h0, seq});
      @(posedge clock);
      pulse <= 1'b1;
    end
    @(posedge clock);
    pulse <= 1'b0;
  endtask : pulse_order

  // A reset in mid-run puts every written register back to its default.
  task automatic reset_again();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reset_values();
  endtask : reset_again

  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reset_values();
    window_fields();
    ctrl_modes();
    gain_select();
    pulse_order();
    reset_again();
    close_out();
  end
endmodule : slot_a_afe_config_regs_test
